// ### rtl/mfp_packer.sv
// Purpose: Turns 12-bit mono samples into a byte stream in the selected format.
// Assumes: Pixel inputs are synchronous to CLK; the byte sink never stalls.
// Notes: The format is latched at each frame start that carries a legal code and holds for the frame.
`timescale 1ns/1ps
`default_nettype none

module mfp_packer (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic FRAME_START,
  input wire logic [2:0] FORMAT_SEL,
  input wire logic PIX_VALID,
  input wire logic [11:0] PIX_DATA,
  output logic PIX_READY,
  output logic BYTE_VALID,
  output logic [7:0] BYTE_DATA,
  output logic [2:0] LEADER_FORMAT
);

  typedef enum logic [1:0] {
    ST_TAKE = 2'b01,
    ST_SECOND = 2'b10
  } mfp_state_type;

  mfp_state_type state_q, state_d;
  logic ready_q, ready_d;
  logic valid_q, valid_d;
  logic [7:0] byte_q, byte_d;
  logic [7:0] held_q, held_d;
  logic odd_q, odd_d;
  logic [3:0] even_low_q, even_low_d;
  logic [2:0] fmt_q, fmt_d;
  logic [2:0] leader_q, leader_d;
  logic [2:0] fmt_now;
  logic odd_now;
  logic accept;

  mfp_if enc_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Encoding of the pixel being taken.

  // A frame start applies a legal new selection to the pixel in the same cycle; an illegal one keeps the old format.
  always_comb begin
    fmt_now = fmt_q;
    odd_now = odd_q;
    if (FRAME_START && ready_q) begin
      odd_now = 1'b0;
      if (mfp_pkg::fmt_legal(FORMAT_SEL)) begin
        fmt_now = FORMAT_SEL;
      end
    end
  end

  assign accept = PIX_VALID && ready_q;
  assign enc_bus.fmt = fmt_now;
  assign enc_bus.pixel = PIX_DATA;
  assign enc_bus.odd = odd_now;
  assign enc_bus.even_low = even_low_q;

  mfp_encoder u_encoder (
    .bus(enc_bus.enc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Byte sequencing and frame state.

  // Next state: send byte a at once, byte b one cycle later with input stalled.
  always_comb begin
    state_d = state_q;
    valid_d = 1'b0;
    byte_d = byte_q;
    held_d = held_q;
    odd_d = odd_now;
    even_low_d = even_low_q;
    fmt_d = fmt_now;
    leader_d = (fmt_now == mfp_pkg::FMT_WIDE_GREY) ? mfp_pkg::LEADER_GREY12 : fmt_now;
    unique case (state_q)
      ST_TAKE: begin
        if (accept) begin
          valid_d = 1'b1;
          byte_d = enc_bus.byte_a;
          held_d = enc_bus.byte_b;
          odd_d = !odd_now;
          if (!odd_now) begin
            even_low_d = PIX_DATA[mfp_pkg::NIB_W-1:0];
          end
          if (enc_bus.two_bytes) begin
            state_d = ST_SECOND;
          end
        end
      end
      ST_SECOND: begin
        valid_d = 1'b1;
        byte_d = held_q;
        state_d = ST_TAKE;
      end
    endcase
    ready_d = (state_d == ST_TAKE);
  end

  // Registers of the sequencer.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_TAKE;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
      byte_q <= mfp_pkg::BYTE_RESET;
      held_q <= mfp_pkg::BYTE_RESET;
      odd_q <= 1'b0;
      even_low_q <= mfp_pkg::UPPER_ZERO;
      fmt_q <= mfp_pkg::FMT_RESET;
      leader_q <= mfp_pkg::FMT_RESET;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      valid_q <= valid_d;
      byte_q <= byte_d;
      held_q <= held_d;
      odd_q <= odd_d;
      even_low_q <= even_low_d;
      fmt_q <= fmt_d;
      leader_q <= leader_d;
    end
  end

  // Outputs straight from flip-flops.
  assign PIX_READY = ready_q;
  assign BYTE_VALID = valid_q;
  assign BYTE_DATA = byte_q;
  assign LEADER_FORMAT = leader_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_take(logic [2:0] f, logic ph);
    accept && fmt_now == f && odd_now == ph;
  endsequence

  sequence s_two_bytes(logic [7:0] a);
    BYTE_VALID && BYTE_DATA == a && !PIX_READY ##1 BYTE_VALID && PIX_READY;
  endsequence

  a_wide_byte_order: assert property (@(posedge CLK) disable iff (!RST_N)
    s_take(mfp_pkg::FMT_WIDE_GREY, 1'b0) or s_take(mfp_pkg::FMT_WIDE_GREY, 1'b1)
    |=> s_two_bytes($past(PIX_DATA[7:0])) ##0 BYTE_DATA == {4'h0, $past(PIX_DATA[11:8], 2)})
    else $error("wide grey word not sent low byte then zero-filled high byte");

  a_wide_upper_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    state_q == ST_SECOND && fmt_q == mfp_pkg::FMT_WIDE_GREY |=> BYTE_DATA[7:4] == 4'h0)
    else $error("wide grey high byte has nonzero upper bits");

  a_packed_even: assert property (@(posedge CLK) disable iff (!RST_N)
    s_take(mfp_pkg::FMT_PACKED12, 1'b0)
    |=> BYTE_VALID && PIX_READY && BYTE_DATA == $past(PIX_DATA[11:4]))
    else $error("packed even pixel byte wrong");

  a_packed_odd: assert property (@(posedge CLK) disable iff (!RST_N)
    s_take(mfp_pkg::FMT_PACKED12, 1'b1)
    |=> s_two_bytes({$past(PIX_DATA[3:0]), $past(even_low_q)}) ##0 BYTE_DATA == $past(PIX_DATA[11:4], 2))
    else $error("packed odd pixel bytes wrong");

  a_chroma_first_pair: assert property (@(posedge CLK) disable iff (!RST_N)
    s_take(mfp_pkg::FMT_CHROMA_FIRST_422, 1'b0) or s_take(mfp_pkg::FMT_CHROMA_FIRST_422, 1'b1)
    |=> s_two_bytes(8'h00) ##0 BYTE_DATA == $past(PIX_DATA[11:4], 2))
    else $error("chroma-first ordering or zero chroma wrong");

  a_luma_first_pair: assert property (@(posedge CLK) disable iff (!RST_N)
    s_take(mfp_pkg::FMT_LUMA_FIRST_422, 1'b0) or s_take(mfp_pkg::FMT_LUMA_FIRST_422, 1'b1)
    |=> s_two_bytes($past(PIX_DATA[11:4])) ##0 BYTE_DATA == 8'h00)
    else $error("luma-first ordering or zero chroma wrong");

  a_grey8_single: assert property (@(posedge CLK) disable iff (!RST_N)
    s_take(mfp_pkg::FMT_GREY8, 1'b0) or s_take(mfp_pkg::FMT_GREY8, 1'b1)
    |=> BYTE_VALID && PIX_READY && BYTE_DATA == $past(PIX_DATA[11:4]))
    else $error("8-bit grey pixel not one upper-bits byte");

  a_leader_grey12: assert property (@(posedge CLK) disable iff (!RST_N)
    fmt_q == mfp_pkg::FMT_WIDE_GREY |-> LEADER_FORMAT == mfp_pkg::LEADER_GREY12)
    else $error("wide grey leader not marked as 12-bit grey");

  a_format_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    !FRAME_START |=> $stable(fmt_q))
    else $error("format changed inside a frame");

  a_chroma_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    accept && fmt_now == mfp_pkg::FMT_LUMA_FIRST_422 |=> ##1 BYTE_DATA == 8'h00)
    else $error("chroma byte not zero");

endmodule
`default_nettype wire

// ### inc/mfp_pkg.sv
// Purpose: Shared constants, format codes and helpers of the mono pixel packer.
// Assumes: 12-bit unsigned sensor samples, one byte sent per clock.
// Notes: Format codes double as the leader codes except where noted.
package mfp_pkg;

  localparam int unsigned PIX_W = 12;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FMT_W = 3;
  localparam int unsigned LUMA_LSB = 4;
  localparam int unsigned NIB_W = 4;

  // Output encodings selectable by the host.
  localparam logic [2:0] FMT_GREY8 = 3'h0;
  localparam logic [2:0] FMT_WIDE_GREY = 3'h1;
  localparam logic [2:0] FMT_PACKED12 = 3'h2;
  localparam logic [2:0] FMT_CHROMA_FIRST_422 = 3'h3;
  localparam logic [2:0] FMT_LUMA_FIRST_422 = 3'h4;

  // Leader code for 12-bit grey, reported when the wide format carries 12 bits.
  localparam logic [2:0] LEADER_GREY12 = 3'h5;

  // Reset values and zero fill constants.
  localparam logic [2:0] FMT_RESET = FMT_GREY8;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] CHROMA_ZERO = 8'h00;
  localparam logic [3:0] UPPER_ZERO = 4'h0;

  // Tells whether a code names a supported encoding.
  function automatic logic fmt_legal(input logic [2:0] f);
    fmt_legal = (f <= FMT_LUMA_FIRST_422);
  endfunction

  // Eight-bit luma is the upper eight bits of the 12-bit sample.
  function automatic logic [7:0] luma_of(input logic [11:0] p);
    luma_of = p[PIX_W-1:LUMA_LSB];
  endfunction

endpackage

// ### inc/mfp_if.sv
// Purpose: Carries one pixel and its encoded bytes between control and encoder.
// Assumes: Purely combinational exchange inside one clock domain.
// Notes: The encoder yields one or two bytes for each pixel.
`timescale 1ns/1ps
`default_nettype none
interface mfp_if;
  logic [2:0] fmt;
  logic [11:0] pixel;
  logic odd;
  logic [3:0] even_low;
  logic two_bytes;
  logic [7:0] byte_a;
  logic [7:0] byte_b;

  modport enc (input fmt, pixel, odd, even_low, output two_bytes, byte_a, byte_b);
  modport ctl (output fmt, pixel, odd, even_low, input two_bytes, byte_a, byte_b);
endinterface
`default_nettype wire

// ### rtl/mfp_encoder.sv
// Purpose: Maps one pixel to its transmitted bytes for the selected encoding.
// Assumes: Caller tracks pixel pair phase and the held even low nibble.
// Notes: Combinational only; byte_b is meaningful when two_bytes is high.
`timescale 1ns/1ps
`default_nettype none
module mfp_encoder (
  mfp_if.enc bus
);

  // Byte selection for each encoding and pair phase.
  always_comb begin
    bus.two_bytes = 1'b0;
    bus.byte_a = mfp_pkg::luma_of(bus.pixel);
    bus.byte_b = mfp_pkg::BYTE_RESET;
    unique case (bus.fmt)
      mfp_pkg::FMT_WIDE_GREY: begin
        bus.two_bytes = 1'b1;
        bus.byte_a = bus.pixel[mfp_pkg::BYTE_W-1:0];
        bus.byte_b = {mfp_pkg::UPPER_ZERO, bus.pixel[mfp_pkg::PIX_W-1:mfp_pkg::BYTE_W]};
      end
      mfp_pkg::FMT_PACKED12: begin
        if (bus.odd) begin
          bus.two_bytes = 1'b1;
          bus.byte_a = {bus.pixel[mfp_pkg::NIB_W-1:0], bus.even_low};
          bus.byte_b = bus.pixel[mfp_pkg::PIX_W-1:mfp_pkg::LUMA_LSB];
        end else begin
          bus.byte_a = bus.pixel[mfp_pkg::PIX_W-1:mfp_pkg::LUMA_LSB];
        end
      end
      mfp_pkg::FMT_CHROMA_FIRST_422: begin
        bus.two_bytes = 1'b1;
        bus.byte_a = mfp_pkg::CHROMA_ZERO;
        bus.byte_b = mfp_pkg::luma_of(bus.pixel);
      end
      mfp_pkg::FMT_LUMA_FIRST_422: begin
        bus.two_bytes = 1'b1;
        bus.byte_a = mfp_pkg::luma_of(bus.pixel);
        bus.byte_b = mfp_pkg::CHROMA_ZERO;
      end
      default: begin
        bus.two_bytes = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### tb/mfp_host_model.sv
// Purpose: Behavioural host that collects the transmitted byte stream of a frame.
// Assumes: Bytes arrive one per clock, qualified by the valid flag; the host never stalls.
// Notes: The bench reads and clears the queue between frames.
`timescale 1ns/1ps
`default_nettype none
module mfp_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data
);
  logic [7:0] q[$];

  // Store each qualified byte in arrival order, as the frame buffer would.
  always @(posedge clk) begin
    if (rst_n === 1'b1 && byte_valid === 1'b1) begin
      q.push_back(byte_data);
    end
  end
endmodule
`default_nettype wire

// ### tb/mfp_packer_tb_top.sv
// Purpose: Self-checking bench for the mono pixel packer, one frame per format.
// Assumes: Inputs change at the falling edge; the host model takes every byte.
// Notes: Expected bytes are built here from the sample values and the format layout.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module mfp_packer_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic frame_start = 1'b0;
  logic [2:0] format_sel = 3'h0;
  logic pix_valid = 1'b0;
  logic [11:0] pix_data = 12'h000;
  logic pix_ready;
  logic byte_valid;
  logic [7:0] byte_data;
  logic [2:0] leader_format;
  int miscompares = 0;
  int num_checks = 0;
  logic [11:0] pix [4] = '{12'hFFF, 12'h000, 12'hA5C, 12'h3B7};
  logic [7:0] exp_q[$];

  // Clock of 40 ns period.
  always #20 clk = ~clk;

  mfp_packer u_mfp_packer (.CLK(clk), .RST_N(rst_n), .FRAME_START(frame_start), .FORMAT_SEL(format_sel),
    .PIX_VALID(pix_valid), .PIX_DATA(pix_data), .PIX_READY(pix_ready), .BYTE_VALID(byte_valid),
    .BYTE_DATA(byte_data), .LEADER_FORMAT(leader_format));
  mfp_host_model u_mfp_host_model (.clk(clk), .rst_n(rst_n), .byte_valid(byte_valid), .byte_data(byte_data));

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Waits until the packer is ready, then offers one pixel.
  task automatic put_pix(input logic fs, input logic [2:0] f, input logic [11:0] d);
    int w;
    w = 0;
    @(negedge clk);
    while (pix_ready !== 1'b1 && w < 8) begin
      @(negedge clk);
      w++;
    end
    `CHK(pix_ready, 1'b1)
    frame_start = fs;
    format_sel = f;
    pix_valid = 1'b1;
    pix_data = d;
  endtask

  // Sends all four samples as one frame, then lets the stream drain.
  task automatic send_frame(input logic [2:0] f);
    for (int i = 0; i < 4; i++) begin
      put_pix(i == 0, f, pix[i]);
    end
    @(negedge clk);
    pix_valid = 1'b0;
    frame_start = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Compares leader code and collected bytes with the expectation, then clears both.
  task automatic check_frame(input logic [2:0] lead, input string name);
    `CHK(leader_format, lead)
    `CHK(u_mfp_host_model.q.size(), exp_q.size())
    foreach (exp_q[i]) begin
      `CHK(u_mfp_host_model.q[i], exp_q[i])
    end
    $display("test %s done", name);
    exp_q.delete();
    u_mfp_host_model.q.delete();
  endtask

  // One byte per sample, the upper eight bits.
  task automatic t_grey8();
    foreach (pix[i]) exp_q.push_back(pix[i][11:4]);
    send_frame(mfp_pkg::FMT_GREY8);
    check_frame(mfp_pkg::FMT_GREY8, "grey8");
  endtask

  // Low byte then zero-padded high byte; leader reports 12-bit grey.
  task automatic t_wide();
    foreach (pix[i]) begin
      exp_q.push_back(pix[i][7:0]);
      exp_q.push_back({4'h0, pix[i][11:8]});
    end
    send_frame(mfp_pkg::FMT_WIDE_GREY);
    check_frame(mfp_pkg::LEADER_GREY12, "wide");
  endtask

  // Two samples in three bytes with shared nibble byte.
  task automatic t_packed(input logic [2:0] f, input string name);
    for (int i = 0; i < 4; i += 2) begin
      exp_q.push_back(pix[i][11:4]);
      exp_q.push_back({pix[i+1][3:0], pix[i][3:0]});
      exp_q.push_back(pix[i+1][11:4]);
    end
    send_frame(f);
    check_frame(mfp_pkg::FMT_PACKED12, name);
  endtask

  // Zero chroma and luma per sample, in either byte order.
  task automatic t_422(input logic [2:0] f, input logic luma_first, input string name);
    foreach (pix[i]) begin
      if (luma_first) begin
        exp_q.push_back(pix[i][11:4]);
        exp_q.push_back(8'h00);
      end else begin
        exp_q.push_back(8'h00);
        exp_q.push_back(pix[i][11:4]);
      end
    end
    send_frame(f);
    check_frame(f, name);
  endtask

  // Reset in the middle of a wide pixel clears outputs and returns to 8-bit grey.
  task automatic t_reset_mid();
    put_pix(1'b1, mfp_pkg::FMT_WIDE_GREY, pix[2]);
    @(negedge clk);
    pix_valid = 1'b0;
    frame_start = 1'b0;
    rst_n = 1'b0;
    #1;
    `CHK(byte_valid, 1'b0)
    `CHK(pix_ready, 1'b1)
    `CHK(byte_data, mfp_pkg::BYTE_RESET)
    `CHK(leader_format, mfp_pkg::FMT_RESET)
    @(negedge clk);
    rst_n = 1'b1;
    u_mfp_host_model.q.delete();
    foreach (pix[i]) exp_q.push_back(pix[i][11:4]);
    send_frame(3'h7);
    check_frame(mfp_pkg::FMT_GREY8, "reset mid frame");
  endtask

  // Main sequence: reset, then one frame per format and an illegal selection.
  initial begin
    repeat (5) @(negedge clk);
    `CHK(byte_valid, 1'b0)
    `CHK(pix_ready, 1'b1)
    `CHK(leader_format, mfp_pkg::FMT_RESET)
    rst_n = 1'b1;
    t_grey8();
    t_wide();
    t_packed(mfp_pkg::FMT_PACKED12, "packed");
    t_packed(3'h7, "illegal keeps packed");
    t_422(mfp_pkg::FMT_CHROMA_FIRST_422, 1'b0, "chroma first");
    t_422(mfp_pkg::FMT_LUMA_FIRST_422, 1'b1, "luma first");
    t_reset_mid();
    tally_and_finish();
  end

  // Watchdog well beyond the fewer than one hundred cycles the frames need.
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
